// ---- rtl/serial_port.sv ----
`timescale 1ns/1ns

module serial_port (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rxd_in,
  output logic             rxd_out,
  output logic             rxd_oe,
  output logic             txd,
  input  wire logic        timer1_overflow,
  input  wire logic        timer2_overflow
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  serial_pkg::control_status_t serial_control_status;
  serial_pkg::serial_mode_t    mode;
  serial_pkg::rx_state_t       rx_state;
  logic [7:0]  port_config;
  logic [7:0]  rx_buffer;
  logic [3:0]  ph;
  logic [3:0]  next_ph;
  logic        six_clock;
  logic        async_mode;
  logic        nine_bit;
  logic        p_s1p1;
  logic        p_s5p2;
  logic        p_s6p2;
  logic        dp_valid;
  logic        dp_write;
  logic [11:0] dp_addr;
  logic        rd_pend;
  logic        wr_serial_control_status;
  logic        wr_serial_buffer;
  logic        wr_cfg;
  logic [2:0]  fixed_cnt;
  logic [2:0]  fixed_div;
  logic        t1_half;
  logic        tick;
  logic [8:0]  tx_sr;
  logic [3:0]  tx_div;
  logic        tx_roll;
  logic        tx_pending;
  logic        tx_wait;
  logic        tx_go;
  logic        tx_send;
  logic        tx_data;
  logic        tx_first;
  logic        tx_last;
  logic        tx_marker;
  logic        ti_set;
  logic [8:0]  rx_sr;
  logic [3:0]  rx_div;
  logic        rx_prev;
  logic        rx_smp;
  logic        rx_arm;
  logic        rx_last;
  logic        rx_first;
  logic        s_a;
  logic        s_b;
  logic        maj;
  logic        rx_bit_time;
  logic        rx_final;
  logic        ri_set;
  logic        rb_load;
  logic        rb_value;
  logic [7:0]  rx_word;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Machine cycle sequencing; in 6-clock mode each state lasts one clock
  assign mode       = serial_pkg::serial_mode_t'({serial_control_status.mode_select_hi, serial_control_status.mode_select_lo});
  assign async_mode = (mode != serial_pkg::mode_shift);
  assign nine_bit   = serial_control_status.mode_select_hi;
  assign six_clock  = port_config[serial_pkg::cfg_six_clock];

  function automatic logic at_ph(input logic [3:0] cur, input logic six, input logic [3:0] p);
    at_ph = six ? (cur == {p[3:1], 1'b0}) : (cur == p);
  endfunction

  function automatic logic [7:0] reverse8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      reverse8[i] = v[7-i];
    end
  endfunction

  always_comb begin
    if (six_clock) begin
      next_ph = (ph >= serial_pkg::ph_s6p1) ? serial_pkg::ph_s1p1 : ph + 4'h2;
    end else begin
      next_ph = (ph == serial_pkg::ph_s6p2) ? serial_pkg::ph_s1p1 : ph + 4'h1;
    end
  end

  assign p_s1p1 = at_ph(ph, six_clock, serial_pkg::ph_s1p1);
  assign p_s5p2 = at_ph(ph, six_clock, serial_pkg::ph_s5p2);
  assign p_s6p2 = at_ph(ph, six_clock, serial_pkg::ph_s6p2);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph <= serial_pkg::ph_s1p1;
    end else begin
      ph <= next_ph;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // 16x bit-rate tick
  assign fixed_div = six_clock ?
                     (port_config[serial_pkg::cfg_rate_double] ? 3'h1 : serial_pkg::fixed_div_6clk) :
                     (port_config[serial_pkg::cfg_rate_double] ? serial_pkg::fixed_div_6clk :
                                                                 serial_pkg::fixed_div_12clk);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fixed_cnt <= 3'h0;
      t1_half   <= 1'b0;
    end else begin
      fixed_cnt <= (fixed_cnt >= fixed_div - 3'h1) ? 3'h0 : fixed_cnt + 3'h1;
      if (timer1_overflow) begin
        t1_half <= ~t1_half;
      end
    end
  end

  always_comb begin
    if (mode == serial_pkg::mode_uart9_fixed) begin
      tick = (fixed_cnt >= fixed_div - 3'h1);
    end else if (port_config[serial_pkg::cfg_timer2_sel]) begin
      tick = timer2_overflow;
    end else begin
      // Halving drops out with rate double set
      tick = timer1_overflow & (port_config[serial_pkg::cfg_rate_double] | t1_half);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero wait, reads one wait so a preceding write is visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid  <= 1'b0;
      dp_write  <= 1'b0;
      dp_addr   <= 12'h000;
      rd_pend   <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hresp <= 1'b0;
      if (hready && hsel && htrans[1]) begin
        dp_valid  <= 1'b1;
        dp_write  <= hwrite;
        dp_addr   <= haddr[11:0];
        rd_pend   <= ~hwrite;
        hreadyout <= hwrite;
      end else if (hready) begin
        dp_valid <= 1'b0;
        dp_write <= 1'b0;
      end
      if (rd_pend) begin
        rd_pend   <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= 32'h0000_0000;
        if (dp_addr == serial_pkg::addr_control_status) begin
          hrdata[7:0] <= serial_control_status;
        end else if (dp_addr == serial_pkg::addr_serial_buffer) begin
          hrdata[7:0] <= rx_buffer;
        end else if (dp_addr == serial_pkg::addr_port_config) begin
          hrdata[7:0] <= port_config;
          hrdata[serial_pkg::cfg_tx_busy] <= tx_send | tx_pending | tx_wait | tx_go;
          hrdata[serial_pkg::cfg_rx_busy] <= (rx_state != serial_pkg::rx_hunt);
        end
      end
    end
  end

  assign wr_serial_control_status = dp_valid && dp_write && (dp_addr == serial_pkg::addr_control_status);
  assign wr_serial_buffer = dp_valid && dp_write && (dp_addr == serial_pkg::addr_serial_buffer);
  assign wr_cfg  = dp_valid && dp_write && (dp_addr == serial_pkg::addr_port_config);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_config <= serial_pkg::port_config_reset;
    end else if (wr_cfg) begin
      port_config <= {5'h00, hwdata[2:0]};
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_control_status <= serial_pkg::control_status_reset;
    end else begin
      if (wr_serial_control_status) begin
        serial_control_status <= hwdata[7:0];
      end
      if (ti_set) begin
        serial_control_status.tx_done_flag <= 1'b1;
      end
      if (ri_set) begin
        serial_control_status.rx_done_flag <= 1'b1;
      end
      if (rb_load) begin
        serial_control_status.rx_ninth_bit <= rb_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Transmitter
  assign tx_roll   = tick && (tx_div == serial_pkg::div_rollover);
  assign tx_marker = (tx_sr[8:2] == 7'h00) && tx_sr[1];
  // Before the first shift the 9-bit modes lack the stop bit, so a marker there is false
  assign ti_set    = (!async_mode && p_s1p1 && tx_last) ||
                     (async_mode && tx_roll && tx_send && tx_data &&
                      tx_marker && !tx_first);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_div <= 4'h0;
    end else if (tick) begin
      tx_div <= tx_div + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sr      <= 9'h000;
      tx_pending <= 1'b0;
      tx_wait    <= 1'b0;
      tx_go      <= 1'b0;
      tx_send    <= 1'b0;
      tx_data    <= 1'b0;
      tx_first   <= 1'b0;
      tx_last    <= 1'b0;
    end else if (wr_serial_buffer) begin
      // Ninth position: marker 1, or the ninth data bit in 9-bit modes
      tx_sr      <= {nine_bit ? serial_control_status.tx_ninth_bit : 1'b1, hwdata[7:0]};
      tx_pending <= 1'b1;
    end else if (!async_mode) begin
      if (p_s6p2) begin
        if (tx_pending) begin
          tx_pending <= 1'b0;
          tx_wait    <= 1'b1;
        end
        if (tx_wait) begin
          tx_wait <= 1'b0;
          tx_go   <= 1'b1;
        end
        if (tx_send) begin
          tx_sr <= {1'b0, tx_sr[8:1]};
          if (tx_marker) begin
            tx_last <= 1'b1;
          end
        end
      end
      if (p_s1p1 && tx_go) begin
        tx_go   <= 1'b0;
        tx_send <= 1'b1;
      end
      if (p_s1p1 && tx_last) begin
        tx_send <= 1'b0;
        tx_last <= 1'b0;
      end
    end else if (tx_roll) begin
      if (!tx_send && tx_pending) begin
        tx_send    <= 1'b1;
        tx_pending <= 1'b0;
        tx_first   <= 1'b1;
      end else if (tx_send && !tx_data) begin
        tx_data <= 1'b1;
      end else if (tx_send) begin
        tx_sr    <= {tx_first & nine_bit, tx_sr[8:1]};
        tx_first <= 1'b0;
        if (tx_marker && !tx_first) begin
          tx_send <= 1'b0;
          tx_data <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Receiver
  assign maj         = (s_a & s_b) | (s_a & rxd_in) | (s_b & rxd_in);
  assign rx_bit_time = tick && (rx_div == serial_pkg::div_sample_c) &&
                       (rx_state == serial_pkg::rx_frame);
  assign rx_final    = rx_bit_time && !rx_first && !rx_sr[8];
  assign rx_word     = reverse8(rx_sr[7:0]);
  // Store only into an empty buffer, and with multiproc on only for a set last bit
  assign rb_load     = async_mode && rx_final && !serial_control_status.rx_done_flag &&
                       (!serial_control_status.multiproc_enable || maj);
  assign rb_value    = maj;
  assign ri_set      = rb_load ||
                       (!async_mode && p_s1p1 && rx_last);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_buffer <= 8'h00;
    end else if (rb_load || (!async_mode && p_s1p1 && rx_last)) begin
      rx_buffer <= rx_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state <= serial_pkg::rx_hunt;
      rx_sr    <= 9'h000;
      rx_div   <= 4'h0;
      rx_prev  <= 1'b1;
      rx_smp   <= 1'b1;
      rx_arm   <= 1'b0;
      rx_last  <= 1'b0;
      rx_first <= 1'b0;
      s_a      <= 1'b1;
      s_b      <= 1'b1;
    end else if (!async_mode) begin
      rx_prev <= 1'b1;
      if (p_s5p2) begin
        rx_smp <= rxd_in;
      end
      case (rx_state)
        serial_pkg::rx_hunt: begin
          if (p_s6p2) begin
            rx_arm <= serial_control_status.rx_enable && !serial_control_status.rx_done_flag;
            if (rx_arm && serial_control_status.rx_enable && !serial_control_status.rx_done_flag) begin
              rx_sr    <= {1'b1, serial_pkg::rx_preload_shift};
              rx_state <= serial_pkg::rx_sync;
              rx_arm   <= 1'b0;
            end
          end
        end
        serial_pkg::rx_sync: begin
          if (p_s6p2) begin
            rx_sr[7:0] <= {rx_sr[6:0], rx_smp};
            if (!rx_sr[7]) begin
              rx_last <= 1'b1;
            end
          end
          if (p_s1p1 && rx_last) begin
            rx_last  <= 1'b0;
            rx_state <= serial_pkg::rx_hunt;
          end
        end
        default: begin
          rx_state <= serial_pkg::rx_hunt;
        end
      endcase
    end else if (tick) begin
      rx_arm  <= 1'b0;
      rx_last <= 1'b0;
      rx_prev <= rxd_in;
      rx_div  <= rx_div + 4'h1;
      if (rx_div == serial_pkg::div_sample_a) begin
        s_a <= rxd_in;
      end
      if (rx_div == serial_pkg::div_sample_b) begin
        s_b <= rxd_in;
      end
      case (rx_state)
        serial_pkg::rx_hunt: begin
          if (serial_control_status.rx_enable && rx_prev && !rxd_in) begin
            rx_div   <= 4'h0;
            rx_sr    <= serial_pkg::rx_preload_async;
            rx_first <= 1'b1;
            rx_state <= serial_pkg::rx_frame;
          end
        end
        serial_pkg::rx_frame: begin
          if (rx_div == serial_pkg::div_sample_c) begin
            rx_first <= 1'b0;
            if (rx_first && maj) begin
              rx_state <= serial_pkg::rx_hunt;
            end else begin
              rx_sr <= {rx_sr[7:0], maj};
              if (!rx_first && !rx_sr[8]) begin
                // 9-bit modes still have a stop bit to let pass
                rx_state <= nine_bit ? serial_pkg::rx_tail : serial_pkg::rx_hunt;
              end
            end
          end
        end
        serial_pkg::rx_tail: begin
          if (rx_div == serial_pkg::div_sample_c) begin
            rx_state <= serial_pkg::rx_hunt;
          end
        end
        default: begin
          rx_state <= serial_pkg::rx_hunt;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pins, registered; mode 0 shift clock low during S3 to S5
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd     <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe  <= 1'b0;
    end else if (!async_mode) begin
      if (tx_send || rx_state == serial_pkg::rx_sync) begin
        txd <= !((next_ph >= serial_pkg::ph_s3p1) && (next_ph <= serial_pkg::ph_s5p2));
      end else begin
        txd <= 1'b1;
      end
      rxd_oe  <= tx_send;
      rxd_out <= tx_send ? tx_sr[0] : 1'b1;
    end else begin
      rxd_oe  <= 1'b0;
      rxd_out <= 1'b1;
      txd     <= tx_send ? (tx_data ? tx_sr[0] : 1'b0) : 1'b1;
    end
  end

endmodule // serial_port

// ---- rtl/serial_pkg.sv ----
package serial_pkg;

  // Register byte addresses (word aligned)
  localparam logic [11:0] addr_control_status = 12'h098;
  localparam logic [11:0] addr_serial_buffer  = 12'h09c;
  localparam logic [11:0] addr_port_config    = 12'h0a0;

  localparam logic [7:0] control_status_reset = 8'h00;
  localparam logic [7:0] port_config_reset    = 8'h00;

  // Port configuration field positions
  localparam int cfg_rate_double  = 0;
  localparam int cfg_six_clock    = 1;
  localparam int cfg_timer2_sel   = 2;
  localparam int cfg_tx_busy      = 4;
  localparam int cfg_rx_busy      = 5;

  // Machine cycle phases: state n phase m is index 2*(n-1)+(m-1)
  localparam logic [3:0] ph_s1p1 = 4'h0;
  localparam logic [3:0] ph_s3p1 = 4'h4;
  localparam logic [3:0] ph_s5p2 = 4'h9;
  localparam logic [3:0] ph_s6p1 = 4'ha;
  localparam logic [3:0] ph_s6p2 = 4'hb;

  // Divide-by-16 counter states
  localparam logic [3:0] div_sample_a = 4'h7;
  localparam logic [3:0] div_sample_b = 4'h8;
  localparam logic [3:0] div_sample_c = 4'h9;
  localparam logic [3:0] div_rollover = 4'hf;

  // Shift register preloads
  localparam logic [7:0] rx_preload_shift = 8'hfe;
  localparam logic [8:0] rx_preload_async = 9'h1ff;

  // Fixed-rate mode oscillator clocks per 16x tick
  localparam logic [2:0] fixed_div_12clk = 3'h4;
  localparam logic [2:0] fixed_div_6clk  = 3'h2;

  localparam logic [1:0] htrans_nonseq = 2'b10;

  typedef enum logic [1:0] {
    mode_shift       = 2'b00,
    mode_uart8_var   = 2'b01,
    mode_uart9_fixed = 2'b10,
    mode_uart9_var   = 2'b11
  } serial_mode_t;

  typedef enum logic [1:0] {
    rx_hunt  = 2'b00,
    rx_sync  = 2'b01,
    rx_frame = 2'b10,
    rx_tail  = 2'b11
  } rx_state_t;

  typedef struct packed {
    logic mode_select_hi;
    logic mode_select_lo;
    logic multiproc_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } control_status_t;

endpackage

// ---- tb/serial_port_chk.sv ----
`timescale 1ns/1ns
module serial_port_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rxd_out,
  input wire logic        rxd_oe,
  input wire logic        txd
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic       take;
  logic [7:0] oe_cnt;

  assign take = hsel && htrans[1] && hready;

  // Clocks spent in the current send window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) oe_cnt <= 8'h00;
    else oe_cnt <= rxd_oe ? oe_cnt + 8'h01 : 8'h00;
  end

  bus_okay_a: assert property (hresp == 1'b0 && hrdata[31:8] == 24'h0)
    else $error("bus response or upper read data wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  read_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data changed outside a read");
  idle_data_a: assert property (!rxd_oe |-> rxd_out)
    else $error("data pin not high outside send");
  clk_low_a: assert property ($fell(txd) && rxd_oe |-> (!txd) [*6] ##1 txd)
    else $error("shift clock low phase wrong");
  clk_high_a: assert property ($rose(txd) && rxd_oe |-> txd [*6])
    else $error("shift clock high phase wrong");
  data_settle_a: assert property (rxd_oe && $changed(rxd_out) |-> txd && $past(txd))
    else $error("data moved while shift clock low");
  send_span_a: assert property ($fell(rxd_oe) |-> oe_cnt == 8'h60)
    else $error("send window not eight cycles");
endmodule // serial_port_chk

bind serial_port serial_port_chk chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));

// ---- tb/serial_peer.sv ----
`timescale 1ns/1ns
module serial_peer (
  input  wire logic hclk,
  input  wire logic txd,
  input  wire logic rxd_out,
  input  wire logic rxd_oe,
  output logic      line
);
  logic [9:0] cap;
  logic [7:0] m0_cap, m0_src;
  logic       async_on;
  int         per, nb, i, m0_n, m0_left;

  initial begin
    line = 1'b1;
    async_on = 1'b0;
    per = 16;
    nb = 10;
    m0_n = 0;
    m0_left = 0;
    cap = 10'h000;
    m0_cap = 8'h00;
  end

  // External shift register: takes data and moves on at each clock rise
  always @(posedge txd) begin
    if (rxd_oe) begin
      m0_cap = {rxd_out, m0_cap[7:1]};
      m0_n++;
    end else if (m0_left > 0) begin
      m0_left--;
      m0_src = m0_src >> 1;
      // Exhausted source shows the inverse, never a stale bit
      line <= (m0_left > 0) ? m0_src[0] : ~line;
    end
  end

  task load0(input logic [7:0] b);
    m0_src = b;
    m0_left = 8;
    line <= b[0];
  endtask

  // Frame receiver on the transmit line, sampling mid-bit
  always @(negedge txd) begin
    if (async_on && !rxd_oe) begin
      repeat (per / 2) @(posedge hclk);
      for (i = 1; i < nb; i++) begin
        repeat (per) @(posedge hclk);
        cap = {txd, cap[9:1]};
      end
    end
  end

  task send(input logic [7:0] d, input logic n9, nine, stp, input int p);
    logic [10:0] f;
    int          k;
    f = n9 ? {stp, nine, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (k = 0; k < (n9 ? 11 : 10); k++) begin
      @(posedge hclk);
      line <= f[k];
      repeat (p - 1) @(posedge hclk);
    end
    @(posedge hclk);
    line <= 1'b1;
  endtask

  task glitch(input int w);
    @(posedge hclk);
    line <= 1'b0;
    repeat (w) @(posedge hclk);
    line <= 1'b1;
  endtask
endmodule // serial_peer

// ---- tb/serial_port_modes_0_to_3_tb_top.sv ----
`timescale 1ns/1ns
module serial_port_modes_0_to_3_tb_top;
  localparam logic [11:0] a_cs  = serial_pkg::addr_control_status;
  localparam logic [11:0] a_buf = serial_pkg::addr_serial_buffer;
  localparam logic [11:0] a_cfg = serial_pkg::addr_port_config;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        rxd_in, rxd_out, rxd_oe, txd, t1_ov, t2_ov;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  last_rx;
  int          err_count, checks_done, cyc;

  serial_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .timer1_overflow(t1_ov),
    .timer2_overflow(t2_ov));
  serial_peer peer (.hclk(hclk), .txd(txd), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .line(rxd_in));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Overflow pulses stand in for the two rate timers
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    t1_ov <= (cyc % 4 == 3);
    t2_ov <= (cyc % 6 == 5);
  end

  ////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= serial_pkg::htrans_nonseq;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task rd(input logic [11:0] a, output logic [31:0] v);
    xfer(1'b0, a, 8'h00, v);
  endtask

  task wait_flag(input int b, output int dt);
    int          t, k;
    logic [31:0] v;
    t = cyc;
    v = 32'h0;
    for (k = 0; k < 100 && v[b] !== 1'b1; k++) rd(a_cs, v);
    dt = cyc - t;
  endtask

  task frame(input logic [7:0] ctl, cfg, input int per, input logic [7:0] d,
             input logic stp, st, gl);
    logic [31:0] v;
    logic [7:0]  nd;
    logic        n9;
    nd = ~d;
    n9 = ctl[7];
    wr(a_cfg, cfg);
    wr(a_cs, ctl);
    peer.per = per;
    peer.nb = n9 ? 11 : 10;
    peer.cap = 10'h000;
    peer.async_on = 1'b1;
    if (gl) peer.glitch(per / 8);
    repeat (per) @(posedge hclk);
    fork
      peer.send(nd, n9, ctl[3], stp, per);
      wr(a_buf, d);
    join
    repeat (3 * per) @(posedge hclk);
    rd(a_cs, v);
    chk("control", {24'h0, ctl[7:3], st & (n9 ? ctl[3] : stp), 1'b1, st | ctl[0]}, v);
    rd(a_buf, v);
    chk("rx buffer", {24'h0, st ? nd : last_rx}, v);
    chk("tx frame", n9 ? {22'h0, 1'b1, ctl[3], d} : {22'h0, 1'b1, d, 1'b0}, {22'h0, peer.cap});
    if (st) last_rx = nd;
    repeat (8 * per) @(posedge hclk);
  endtask

  ////////////////////////////////////////
  task t_regs;
    logic [31:0] v;
    rd(a_cs, v);
    chk("control reset", {24'h0, serial_pkg::control_status_reset}, v);
    rd(a_cfg, v);
    chk("config reset", {24'h0, serial_pkg::port_config_reset}, v);
    wr(a_cs, 8'he8);
    rd(a_cs, v);
    chk("control rw", 32'he8, v);
    wr(12'h0f0, 8'h5a);
    rd(12'h0f0, v);
    chk("unmapped", 32'h0, v);
    wr(a_cs, 8'h00);
  endtask

  task t_shift_tx;
    int dt;
    peer.m0_n = 0;
    wr(a_buf, 8'ha5);
    wait_flag(1, dt);
    chk("shift tx time", 32'h1, {31'h0, dt >= 110 && dt <= 130});
    chk("shift tx data", 32'ha5, {24'h0, peer.m0_cap});
    chk("shift tx bits", 32'h8, peer.m0_n);
  endtask

  task t_shift_rx;
    int          dt;
    logic [31:0] v;
    peer.load0(8'h6c);
    wr(a_cs, 8'h10);
    wait_flag(0, dt);
    chk("shift rx time", 32'h1, {31'h0, dt >= 110 && dt <= 130});
    rd(a_buf, v);
    chk("shift rx data", 32'h6c, v);
    last_rx = 8'h6c;
    wr(a_cs, 8'h00);
  endtask

  task t_async_rates;
    frame(8'h98, 8'h00, 64, 8'h3c, 1'b1, 1'b1, 1'b0);
    frame(8'h90, 8'h01, 32, 8'hc3, 1'b1, 1'b1, 1'b0);
    frame(8'h98, 8'h02, 32, 8'h5a, 1'b1, 1'b1, 1'b0);
    frame(8'h90, 8'h03, 16, 8'ha5, 1'b1, 1'b1, 1'b0);
    frame(8'h90, 8'h03, 16, 8'h02, 1'b1, 1'b1, 1'b0);
    frame(8'h50, 8'h00, 128, 8'h96, 1'b1, 1'b1, 1'b0);
    frame(8'h50, 8'h01, 64, 8'h69, 1'b1, 1'b1, 1'b0);
    frame(8'hd8, 8'h04, 96, 8'h0f, 1'b1, 1'b1, 1'b0);
  endtask

  task t_async_filter;
    frame(8'hf0, 8'h04, 96, 8'hf0, 1'b1, 1'b0, 1'b0);
    frame(8'hf8, 8'h04, 96, 8'h12, 1'b1, 1'b1, 1'b0);
    frame(8'h70, 8'h01, 64, 8'h34, 1'b0, 1'b0, 1'b0);
    frame(8'h50, 8'h01, 64, 8'h56, 1'b1, 1'b1, 1'b1);
    frame(8'h91, 8'h01, 32, 8'h78, 1'b1, 1'b0, 1'b0);
    frame(8'h80, 8'h01, 32, 8'h9a, 1'b1, 1'b0, 1'b0);
  endtask

  task conclude;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    cyc = 0;
    err_count = 0;
    checks_done = 0;
    last_rx = 8'h00;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    t1_ov = 1'b0;
    t2_ov = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_shift_tx;
    t_shift_rx;
    t_async_rates;
    t_async_filter;
    conclude;
  end

  // Whole run needs about 19300 clocks
  initial begin
    repeat (60000) @(posedge hclk);
    err_count++;
    $display("[FAIL] watchdog expected done seen hang");
    conclude;
  end
endmodule // serial_port_modes_0_to_3_tb_top
